// ---- common/dacs_pkg.sv ----
// dacs_pkg: shared constants and state encoding of the dram access sequencer.
// assumes one 20 MHz processor clock and a page-mode dram behind the block.
//
// Function
// - Basic access returns data after 3 clocks, or 4 with cycle extend.
// - Row strobe stays inactive at least 2 clocks between row cycles.
// - Back-to-back simple accesses start 5 clocks apart, 6 with extend.
// - Cycle extend adds one wait after T1 of an access, and after T3 and T5 of a refresh.
// - Refresh is row-strobe only; requests during it get one fixed timing.
// - Cycle extend lengthens a contended refresh at T3, T5 and T6.
// - All outputs registered except row address, which follows address.
// - Burst-last indicator ends a burst early, e.g. after two words.
// - First burst word uses the same sequence as a simple access.
// - Row reuse serves a same-row access without a new row activation.
// - Row reuse miss closes the row and waits out precharge first.
// - Row reuse is enabled separately for instruction and data access.
package dacs_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLK_HZ        = 1000000000 / CLK_PERIOD_NS;

  // ****************************************************************
  // address layout defaults (word address)
  // ****************************************************************
  localparam int ADDR_W_DEF  = 24;
  localparam int ROW_W_DEF   = 11;
  localparam int COL_W_DEF   = 11;
  localparam int COL_LSB     = 0;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_ROW   = 4'h1,
    ST_EXT   = 4'h2,
    ST_COL   = 4'h3,
    ST_DATA  = 4'h4,
    ST_BURST = 4'h5,
    ST_PRE1  = 4'h6,
    ST_PRE2  = 4'h7,
    ST_PREX  = 4'h8,
    ST_OPEN  = 4'h9,
    ST_REF1  = 4'ha,
    ST_REF2  = 4'hb,
    ST_REF3  = 4'hc,
    ST_REFX  = 4'hd
  } dacs_state_e;

endpackage

// ---- hdl/dacs_reset_sync.sv ----
// dacs_reset_sync: two-stage release of an active-low asynchronous reset.
// assumes the reset may fall at any time and rises unrelated to the clock.
`timescale 1ns/1ps
module dacs_reset_sync (
  // clock and raw reset
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  // synchronised reset
  output logic      sync_resetn_o
);

  logic stage1;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage1        <= 1'b0;
      sync_resetn_o <= 1'b0;
    end else begin
      stage1        <= 1'b1;
      sync_resetn_o <= stage1;
    end
  end

endmodule

// ---- hdl/dacs_sequencer.sv ----
// dacs_sequencer: access, burst, refresh and row-reuse cycle sequencing.
// assumes the processor holds no second request before the last ready of
// the previous one, and an external timer raises refresh_req_i as a level.
`timescale 1ns/1ps
module dacs_sequencer #(
  parameter int ADDR_W = dacs_pkg::ADDR_W_DEF,
  parameter int ROW_W  = dacs_pkg::ROW_W_DEF,
  parameter int COL_W  = dacs_pkg::COL_W_DEF
) (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              resetn_i,
  // processor request
  input  wire logic              req_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              write_i,
  input  wire logic              instr_i,
  input  wire logic              burst_i,
  input  wire logic              burst_last_indicator_i,
  output logic                   ready_o,
  // configuration levels
  input  wire logic              cycle_extend_i,
  input  wire logic              instr_open_row_reuse_i,
  input  wire logic              data_open_row_reuse_i,
  // refresh
  input  wire logic              refresh_req_i,
  output logic                   refreshing_o,
  // dram
  output logic [ROW_W-1:0]       row_addr_o,
  output logic [COL_W-1:0]       col_addr_o,
  output logic                   ras_n_o,
  output logic                   cas_n_o,
  output logic                   we_n_o
);

  // ****************************************************************
  // parameter check
  // ****************************************************************
  if (ROW_W + COL_W > ADDR_W || ROW_W < 1 || COL_W < 1) begin : g_chk
    $error("dacs_sequencer: row and column widths do not fit the address");
  end

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_n;

  dacs_reset_sync u_rst (
    .sys_clk_i     (sys_clk_i),
    .resetn_i      (resetn_i),
    .sync_resetn_o (rst_n)
  );

  // ****************************************************************
  // request capture and decode
  // ****************************************************************
  dacs_pkg::dacs_state_e state;
  dacs_pkg::dacs_state_e next_state;

  logic              pend_q;
  logic [ADDR_W-1:0] addr_q;
  logic              write_q;
  logic              instr_q;
  logic              burst_q;
  logic              ref_tail_q;
  logic [ROW_W-1:0]  open_row_q;

  wire [ADDR_W-1:0] cur_addr  = req_i ? addr_i : addr_q;
  wire              cur_write = req_i ? write_i : write_q;
  wire              cur_instr = req_i ? instr_i : instr_q;
  wire [ROW_W-1:0]  cur_row   = cur_addr[dacs_pkg::COL_LSB+COL_W +: ROW_W];
  wire [COL_W-1:0]  cur_col   = cur_addr[dacs_pkg::COL_LSB +: COL_W];
  wire              want      = req_i | pend_q;
  wire              row_hit   = (cur_row == open_row_q);
  // reuse choice follows the kind of the access that just finished
  wire              reuse_sel = instr_q ? instr_open_row_reuse_i
                                        : data_open_row_reuse_i;
  // refresh precharge gets its own extra cycle in extend mode
  wire              pre_end   = (state == dacs_pkg::ST_PRE2
                                 && !(ref_tail_q && cycle_extend_i))
                                || state == dacs_pkg::ST_PREX;
  wire              seq_free  = state == dacs_pkg::ST_IDLE || pre_end;
  wire              last_word = burst_last_indicator_i || !burst_q;
  wire              word_cyc  = state == dacs_pkg::ST_DATA
                                || state == dacs_pkg::ST_BURST;
  wire              take_row  = seq_free && !refresh_req_i && want;
  wire              take_hit  = state == dacs_pkg::ST_OPEN && want
                                && row_hit && !refresh_req_i;
  wire              take      = take_row || take_hit;

  // row address is the one combinational output path
  assign row_addr_o = addr_i[dacs_pkg::COL_LSB+COL_W +: ROW_W];

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    case (state)
      dacs_pkg::ST_IDLE, dacs_pkg::ST_PRE2, dacs_pkg::ST_PREX: begin
        if (state == dacs_pkg::ST_PRE2 && !pre_end) begin
          next_state = dacs_pkg::ST_PREX;
        end else if (refresh_req_i) begin
          // refresh wins; the contending request waits in pend_q
          next_state = dacs_pkg::ST_REF1;
        end else if (want) begin
          next_state = dacs_pkg::ST_ROW;
        end else begin
          next_state = dacs_pkg::ST_IDLE;
        end
      end
      dacs_pkg::ST_ROW: begin
        // first burst word shares this path with a simple access
        next_state = cycle_extend_i ? dacs_pkg::ST_EXT
                                    : dacs_pkg::ST_COL;
      end
      dacs_pkg::ST_EXT:  next_state = dacs_pkg::ST_COL;
      dacs_pkg::ST_COL:  next_state = dacs_pkg::ST_DATA;
      dacs_pkg::ST_DATA, dacs_pkg::ST_BURST: begin
        if (!last_word) begin
          next_state = dacs_pkg::ST_BURST;
        end else if (reuse_sel) begin
          next_state = dacs_pkg::ST_OPEN;
        end else begin
          next_state = dacs_pkg::ST_PRE1;
        end
      end
      dacs_pkg::ST_PRE1: next_state = dacs_pkg::ST_PRE2;
      dacs_pkg::ST_OPEN: begin
        if (take_hit) begin
          next_state = cycle_extend_i ? dacs_pkg::ST_EXT
                                      : dacs_pkg::ST_COL;
        end else if (refresh_req_i || want) begin
          // miss or refresh: close the row, precharge, then reopen or refresh
          next_state = dacs_pkg::ST_PRE1;
        end else begin
          next_state = dacs_pkg::ST_OPEN;
        end
      end
      dacs_pkg::ST_REF1: next_state = dacs_pkg::ST_REF2;
      dacs_pkg::ST_REF2: next_state = dacs_pkg::ST_REF3;
      dacs_pkg::ST_REF3: begin
        next_state = cycle_extend_i ? dacs_pkg::ST_REFX
                                    : dacs_pkg::ST_PRE1;
      end
      dacs_pkg::ST_REFX: next_state = dacs_pkg::ST_PRE1;
      default:           next_state = dacs_pkg::ST_IDLE;
    endcase
  end

  // ****************************************************************
  // registered output values
  // ****************************************************************
  wire next_ras  = !(next_state == dacs_pkg::ST_IDLE
                     || next_state == dacs_pkg::ST_PRE1
                     || next_state == dacs_pkg::ST_PRE2
                     || next_state == dacs_pkg::ST_PREX);
  wire next_cas  = next_state == dacs_pkg::ST_COL
                   || next_state == dacs_pkg::ST_DATA
                   || next_state == dacs_pkg::ST_BURST;
  wire next_rdy  = next_state == dacs_pkg::ST_DATA
                   || next_state == dacs_pkg::ST_BURST;
  wire next_refr = next_state == dacs_pkg::ST_REF1
                   || next_state == dacs_pkg::ST_REF2
                   || next_state == dacs_pkg::ST_REF3
                   || next_state == dacs_pkg::ST_REFX;
  wire [COL_W-1:0] next_col =
    (next_state == dacs_pkg::ST_COL)   ? cur_col :
    (next_state == dacs_pkg::ST_BURST) ? col_addr_o + 1'b1 : col_addr_o;

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state   <= dacs_pkg::ST_IDLE;
      ras_n_o <= 1'b1;
      cas_n_o <= 1'b1;
      we_n_o  <= 1'b1;
      ready_o <= 1'b0;
      refreshing_o <= 1'b0;
      col_addr_o   <= '0;
    end else begin
      state   <= next_state;
      ras_n_o <= !next_ras;
      cas_n_o <= !next_cas;
      we_n_o  <= !(next_cas && cur_write);
      ready_o <= next_rdy;
      refreshing_o <= next_refr;
      col_addr_o   <= next_col;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pend_q     <= 1'b0;
      addr_q     <= '0;
      write_q    <= 1'b0;
      instr_q    <= 1'b0;
      burst_q    <= 1'b0;
      ref_tail_q <= 1'b0;
      open_row_q <= '0;
    end else begin
      pend_q <= want && !take;
      if (req_i) begin
        addr_q  <= addr_i;
        write_q <= write_i;
        instr_q <= instr_i;
        burst_q <= burst_i;
      end
      if (next_state == dacs_pkg::ST_ROW) begin
        open_row_q <= cur_row;
      end
      if (state == dacs_pkg::ST_REF1) begin
        ref_tail_q <= 1'b1;
      end else if (pre_end) begin
        ref_tail_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  a_basic_data_lat: assert property (
    (state == dacs_pkg::ST_IDLE && take_row && !cycle_extend_i)
      |-> !ready_o ##3 ready_o)
    else $error("basic access data not at third clock");
  a_ras_precharge: assert property (
    $rose(ras_n_o) |-> ras_n_o [*2])
    else $error("row strobe precharge shorter than two clocks");
  a_row_start_gap: assert property (
    $fell(ras_n_o) |=> !$fell(ras_n_o) [*4])
    else $error("row cycles started closer than five clocks");
  a_ext_wait_state: assert property (
    (state == dacs_pkg::ST_ROW && cycle_extend_i)
      |=> state == dacs_pkg::ST_EXT ##1 state == dacs_pkg::ST_COL)
    else $error("extend wait not inserted after row cycle");
  a_refresh_no_cas: assert property (
    $rose(refreshing_o) |-> (cas_n_o && !ras_n_o) [*3])
    else $error("refresh is not row strobe only");
  a_refresh_extend: assert property (
    (state == dacs_pkg::ST_REF3 && cycle_extend_i)
      |=> state == dacs_pkg::ST_REFX)
    else $error("extend cycle missing in refresh");
  a_burst_last_end: assert property (
    (word_cyc && burst_last_indicator_i) |=> !ready_o && cas_n_o)
    else $error("burst did not end on burst-last indicator");
  a_burst_stream: assert property (
    (word_cyc && burst_q && !burst_last_indicator_i)
      |=> ready_o && !cas_n_o && col_addr_o == $past(col_addr_o) + 1'b1)
    else $error("burst word missing in next clock");
  a_reuse_hit_open: assert property (
    take_hit |=> !ras_n_o ##1 !ras_n_o)
    else $error("row reuse hit reopened the row");
  a_reuse_miss: assert property (
    (state == dacs_pkg::ST_OPEN && want && !row_hit)
      |=> state == dacs_pkg::ST_PRE1 ##1 state == dacs_pkg::ST_PRE2)
    else $error("row reuse miss did not precharge");
  a_reuse_select: assert property (
    (word_cyc && last_word && !reuse_sel) |=> ras_n_o)
    else $error("row kept open with reuse disabled");

  c_simple_access: cover property (
    state == dacs_pkg::ST_IDLE && take_row ##3 ready_o);
  c_two_word_burst: cover property (
    state == dacs_pkg::ST_DATA && burst_q ##1 burst_last_indicator_i);
  c_reuse_hit: cover property (take_hit);
  c_refresh_contend: cover property (refreshing_o && want);

endmodule

// ---- verification/dacs_cpu_model.sv ----
// dacs_cpu_model: processor side of the burst bus, driven by bench tasks.
// assumes one request at a time and ready_i registered on sys_clk_i.
`timescale 1ns/1ps
module dacs_cpu_model (
  // clock and answer
  input  wire logic        sys_clk_i,
  input  wire logic        ready_i,
  input  wire logic [10:0] col_i,
  // request
  output logic             req_o,
  output logic [23:0]      addr_o,
  output logic             write_o,
  output logic             instr_o,
  output logic             burst_o,
  output logic             last_o
);
  // ****************************************************************
  // one transfer; latency counted from the edge that samples the request
  // ****************************************************************
  initial begin
    {req_o, write_o, instr_o, burst_o, last_o} = 5'h00;
    addr_o = 24'h000000;
  end

  task automatic xfer(input logic [23:0] a, input logic wr, input logic ins,
                      input int words, output int lat, output int gaps,
                      output logic [10:0] c0, output logic [10:0] c1);
    int seen;
    int n;
    seen = 0;
    n = 0;
    gaps = 0;
    lat = 0;
    @(posedge sys_clk_i);
    #5;
    last_o = 1'b0;
    {req_o, write_o, instr_o, burst_o} = {1'b1, wr, ins, words > 1};
    addr_o = a;
    @(posedge sys_clk_i);
    #5;
    req_o = 1'b0;
    while (seen < words && n < 40) begin
      @(posedge sys_clk_i);
      #5;
      n++;
      if (ready_i === 1'b1) begin
        seen++;
        if (seen == 1) begin
          // ready seen just after edge n is sampled at edge n+1
          lat = n + 1;
          c0 = col_i;
        end
        c1 = col_i;
        // indicator stands while the last word's ready is sampled
        last_o = (seen == words);
      end else if (seen > 0) begin
        gaps++;
      end
    end
  endtask
endmodule

// ---- verification/dacs_sequencer_test.sv ----
// dacs_sequencer_test: self-checking bench of the access sequencer.
// assumes dacs_pkg, the design and dacs_cpu_model are compiled first.
`timescale 1ns/1ps
module dacs_sequencer_test;
  // ****************************************************************
  // clock, reset, design and partner
  // ****************************************************************
  localparam int DLY = 5;
  // all scenarios need well under a thousand clocks
  localparam int TIMEOUT_CYC = 3000;
  logic        sys_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        ext, i_reuse, d_reuse, refresh_req;
  logic        req, write, instr, burst, last, ready, refreshing;
  logic        ras_n, cas_n, we_n;
  logic [23:0] addr;
  logic [10:0] row, col;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          we_cnt = 0;
  int          fall_cyc, fall_gap, fall_cnt, hi_run, min_hi;
  logic        ras_prev = 1'b1;

  always #25 sys_clk_i = ~sys_clk_i;

  dacs_sequencer dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .req_i(req), .addr_i(addr), .write_i(write), .instr_i(instr),
    .burst_i(burst), .burst_last_indicator_i(last), .ready_o(ready),
    .cycle_extend_i(ext), .instr_open_row_reuse_i(i_reuse),
    .data_open_row_reuse_i(d_reuse), .refresh_req_i(refresh_req),
    .refreshing_o(refreshing), .row_addr_o(row), .col_addr_o(col),
    .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n));

  dacs_cpu_model cpu (.sys_clk_i(sys_clk_i), .ready_i(ready), .col_i(col),
    .req_o(req), .addr_o(addr), .write_o(write), .instr_o(instr),
    .burst_o(burst), .last_o(last));

  // ****************************************************************
  // row strobe watch and run limit
  // ****************************************************************
  always @(posedge sys_clk_i) begin
    cyc++;
    if (we_n === 1'b0) we_cnt++;
    if (ras_prev === 1'b1 && ras_n === 1'b0) begin
      fall_gap = cyc - fall_cyc;
      fall_cyc = cyc;
      fall_cnt++;
      if (hi_run < min_hi) min_hi = hi_run;
    end
    hi_run = (ras_n === 1'b1) ? hi_run + 1 : 0;
    ras_prev = ras_n;
  end

  always @(posedge sys_clk_i) begin
    if (cyc >= TIMEOUT_CYC) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      report_and_stop();
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk_num(input int got, input int exp, input string what);
    comparisons++;
    if (got != exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic chk_sig(input logic [10:0] got, input logic [10:0] exp,
                         input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #DLY;
  endtask

  // latency of first word, then words back to back with rising column
  task automatic access(input logic [23:0] a, input logic wr,
                        input logic ins, input int words, input int exp_lat);
    int lat, gaps;
    logic [10:0] c0, c1;
    cpu.xfer(a, wr, ins, words, lat, gaps, c0, c1);
    chk_num(lat, exp_lat, "first word latency");
    chk_num(gaps, 0, "idle cycles inside burst");
    chk_sig(c0, a[10:0], "first column");
    chk_sig(c1, a[10:0] + 11'(words - 1), "last column");
  endtask

  task automatic ref_watch(input int exp_len);
    int len, only_row;
    len = 0;
    only_row = 0;
    @(posedge sys_clk_i);
    #DLY;
    refresh_req = 1'b1;
    repeat (20) begin
      @(posedge sys_clk_i);
      #DLY;
      if (refreshing === 1'b1) begin
        refresh_req = 1'b0;
        len++;
        if (cas_n === 1'b1 && ras_n === 1'b0) only_row++;
      end
    end
    chk_num(len, exp_len, "refresh length");
    chk_num(only_row, exp_len, "row strobe only refresh");
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_simple;
    for (int e = 0; e < 2; e++) begin
      // start from idle so no precharge wait hides in the latency
      idle(4);
      ext = e[0];
      access(24'h123456, 1'b0, 1'b0, 1, 3 + e);
      chk_sig(row, 11'h246, "row follows address");
    end
    cpu.addr_o = 24'h3ff801;
    #1;
    chk_sig(row, 11'h7ff, "row without request");
    $display("test simple done");
  endtask

  task automatic t_b2b;
    for (int e = 0; e < 2; e++) begin
      ext = e[0];
      idle(4);
      access(24'h001010, 1'b0, 1'b0, 1, 3 + e);
      min_hi = 99;
      // second request arrives one clock before precharge ends
      access(24'h002020, 1'b1, 1'b0, 1, 4 + e);
      chk_num(fall_gap, 5 + e, "row strobe spacing");
      chk_num(min_hi, 2, "row strobe precharge");
    end
    $display("test back to back done");
  endtask

  task automatic t_burst;
    int w0;
    ext = 1'b0;
    idle(4);
    access(24'h004400, 1'b0, 1'b0, 2, 3);
    w0 = we_cnt;
    // each later burst waits one clock for the precharge to end
    access(24'h005503, 1'b1, 1'b0, 4, 4);
    ext = 1'b1;
    access(24'h006600, 1'b0, 1'b1, 3, 5);
    chk_num(we_cnt - w0, 5, "write strobe cycles");
    $display("test burst done");
  endtask

  task automatic t_refresh;
    for (int e = 0; e < 2; e++) begin
      ext = e[0];
      idle(6);
      fork
        access(24'h007001, 1'b0, 1'b0, 1, 8 + 3 * e);
        ref_watch(3 + e);
      join
    end
    $display("test refresh done");
  endtask

  task automatic t_reuse;
    int f0;
    ext = 1'b0;
    d_reuse = 1'b1;
    idle(6);
    access(24'h000800, 1'b0, 1'b0, 1, 3);
    f0 = fall_cnt;
    access(24'h000810, 1'b0, 1'b0, 1, 2);
    chk_num(fall_cnt - f0, 0, "no new row on hit");
    access(24'h001000, 1'b0, 1'b0, 1, 5);
    access(24'h001004, 1'b0, 1'b1, 1, 2);
    idle(4);
    access(24'h001008, 1'b0, 1'b0, 1, 3);
    // data reuse off: row closes although the next access hits it
    i_reuse = 1'b1;
    d_reuse = 1'b0;
    access(24'h00100c, 1'b0, 1'b1, 1, 4);
    access(24'h001010, 1'b0, 1'b1, 1, 2);
    $display("test row reuse done");
  endtask

  initial begin
    {ext, i_reuse, d_reuse, refresh_req} = 4'h0;
    {fall_cyc, fall_gap, fall_cnt, hi_run} = {32'd0, 32'd0, 32'd0, 32'd0};
    min_hi = 99;
    repeat (8) @(posedge sys_clk_i);
    #DLY;
    resetn_i = 1'b1;
    idle(3);
    t_simple();
    t_b2b();
    t_burst();
    t_refresh();
    t_reuse();
    report_and_stop();
  end
endmodule
